// >>> design/boot_loader_defs.vh
/*
 * shared constants for the serial boot loader: framing, rates, phases.
 * assumes a single 200 MHz core clock.
 */
`ifndef BOOT_LOADER_DEFS_VH
`define BOOT_LOADER_DEFS_VH

`define CLK_HZ 200000000
`define BAUD_RATE 1200
`define BIT_CYCLES (`CLK_HZ / `BAUD_RATE)
`define SYNC_BYTE 8'hff
`define BOOT_LEN 25
`define PROG_CYCLES 4000
`define PORTC0_ON 1'b0
`define PORTC0_OFF 1'b1

`endif

// >>> design/byte_buffer.v
/*
 * two-entry buffer with valid/ready on both sides.
 * assumes source and sink share core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module byte_buffer #(
	parameter WIDTH = 8
) (
	input wire core_clk,
	input wire sys_rst,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem_reg [0:1];
	reg wr_ptr_reg;
	reg rd_ptr_reg;
	reg [1:0] count_reg;
	wire push;
	wire pop;

	assign in_ready = (count_reg != 2'd2);
	assign out_valid = (count_reg != 2'd0);
	assign out_data = mem_reg[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always @(posedge core_clk) begin
		if (sys_rst) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg <= 2'd0;
		end else begin
			if (push) begin
				mem_reg[wr_ptr_reg] <= in_data;
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			if (push && !pop)
				count_reg <= count_reg + 2'd1;
			else if (pop && !push)
				count_reg <= count_reg - 2'd1;
		end
	end
endmodule
`default_nettype wire

// >>> design/serial_boot_eprom_loader.v
/*
 * serial boot and eprom programming path: uart at a fixed 1200 baud, sync-byte wait,
 * echoed boot download, then program-and-readback of a local eprom array.
 * assumes rx_pin is asynchronous and the host paces data with one byte in flight.
 */
`timescale 1ns/1ps
`include "boot_loader_defs.vh"
`default_nettype none

// Summary of operation
// - a sync byte precedes the boot code and the receiver then stays at 1200 baud.
// - every boot code byte received is echoed back to the host.
// - after the last boot code byte the device starts the loaded code by itself.
// - the loaded code drives port c bit 0 low, clears the one address pointer prog_addr and enters the programming routine.
// - one received byte is held in a buffer while the next one arrives.
// - after each byte is programmed its location is read back and sent to the host.
module serial_boot_eprom_loader #(
	parameter BIT_CYCLES = `BIT_CYCLES,
	parameter BOOT_LEN = `BOOT_LEN,
	parameter PROG_CYCLES = `PROG_CYCLES,
	parameter ADDR_W = 13
) (
	input wire core_clk,
	input wire sys_rst,
	input wire rx_pin,
	output reg tx_pin,
	output reg portc0,
	output reg booted,
	output reg [ADDR_W-1:0] prog_addr
);
	localparam S_SYNC = 3'd0;
	localparam S_BOOT = 3'd1;
	localparam S_RUN = 3'd2;
	localparam S_PROG = 3'd3;
	localparam S_READ = 3'd4;
	localparam S_SEND = 3'd5;

	// ---------------------------------------------------------------
	// receiver
	// ---------------------------------------------------------------
	reg rx_meta_reg, rx_sync_reg;
	reg rx_busy_reg;
	// wide enough for a full-rate bit time at the core clock
	reg [23:0] rx_cnt_reg;
	reg [3:0] rx_bit_reg;
	reg [7:0] rx_shift_reg;
	reg rx_valid_reg;
	wire buf_in_ready;
	wire [7:0] buf_data;
	wire buf_valid;
	reg buf_pop;

	always @(posedge core_clk) begin
		if (sys_rst) begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
		end else begin
			rx_meta_reg <= rx_pin;
			rx_sync_reg <= rx_meta_reg;
		end
	end

	// fixed rate from reset on; the sync byte needs no autobaud here
	always @(posedge core_clk) begin
		if (sys_rst) begin
			rx_busy_reg <= 1'b0;
			rx_cnt_reg <= 24'h000000;
			rx_bit_reg <= 4'h0;
			rx_shift_reg <= 8'h00;
			rx_valid_reg <= 1'b0;
		end else begin
			if (rx_valid_reg && buf_in_ready)
				rx_valid_reg <= 1'b0;
			if (!rx_busy_reg) begin
				if (!rx_sync_reg) begin
					rx_busy_reg <= 1'b1;
					rx_cnt_reg <= BIT_CYCLES[23:0] >> 1;
					rx_bit_reg <= 4'h0;
				end
			end else if (rx_cnt_reg != 24'h000000) begin
				rx_cnt_reg <= rx_cnt_reg - 24'h000001;
			end else begin
				rx_cnt_reg <= BIT_CYCLES[23:0] - 24'h000001;
				rx_bit_reg <= rx_bit_reg + 4'h1;
				if (rx_bit_reg == 4'h0) begin
					if (rx_sync_reg)
						rx_busy_reg <= 1'b0; // glitch, not a start bit
				end else if (rx_bit_reg < 4'h9) begin
					rx_shift_reg <= {rx_sync_reg, rx_shift_reg[7:1]};
				end else begin
					rx_busy_reg <= 1'b0;
					if (rx_sync_reg)
						rx_valid_reg <= 1'b1;
				end
			end
		end
	end

	byte_buffer #(.WIDTH(8)) rx_buf (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.in_data(rx_shift_reg),
		.in_valid(rx_valid_reg),
		.in_ready(buf_in_ready),
		.out_data(buf_data),
		.out_valid(buf_valid),
		.out_ready(buf_pop)
	);

	// ---------------------------------------------------------------
	// transmitter
	// ---------------------------------------------------------------
	reg tx_busy_reg;
	reg [23:0] tx_cnt_reg;
	reg [3:0] tx_bit_reg;
	reg [9:0] tx_frame_reg;
	reg tx_start;
	reg [7:0] tx_byte;

	always @(posedge core_clk) begin
		if (sys_rst) begin
			tx_busy_reg <= 1'b0;
			tx_cnt_reg <= 24'h000000;
			tx_bit_reg <= 4'h0;
			tx_frame_reg <= 10'h3ff;
			tx_pin <= 1'b1;
		end else if (!tx_busy_reg) begin
			tx_pin <= 1'b1;
			if (tx_start) begin
				tx_busy_reg <= 1'b1;
				tx_frame_reg <= {1'b1, tx_byte, 1'b0};
				tx_cnt_reg <= 24'h000000;
				tx_bit_reg <= 4'h0;
			end
		end else if (tx_cnt_reg != 24'h000000) begin
			tx_cnt_reg <= tx_cnt_reg - 24'h000001;
		end else if (tx_bit_reg == 4'ha) begin
			tx_busy_reg <= 1'b0;
		end else begin
			tx_pin <= tx_frame_reg[0];
			tx_frame_reg <= {1'b1, tx_frame_reg[9:1]};
			tx_cnt_reg <= BIT_CYCLES[23:0] - 24'h000001;
			tx_bit_reg <= tx_bit_reg + 4'h1;
		end
	end

	// ---------------------------------------------------------------
	// boot and programming sequencer
	// ---------------------------------------------------------------
	reg [2:0] state_reg;
	reg [7:0] boot_mem [0:255];
	reg [7:0] eprom [0:(1<<ADDR_W)-1];
	reg [7:0] boot_cnt_reg;
	reg [15:0] prog_cnt_reg;
	reg [7:0] prog_data_reg;
	reg [7:0] read_reg;

	always @* begin
		buf_pop = 1'b0;
		tx_start = 1'b0;
		tx_byte = buf_data;
		case (state_reg)
		S_SYNC: buf_pop = buf_valid;
		S_BOOT: begin
			buf_pop = buf_valid && !tx_busy_reg;
			tx_start = buf_pop;
		end
		S_RUN: buf_pop = buf_valid;
		S_SEND: begin
			tx_byte = read_reg;
			tx_start = !tx_busy_reg;
		end
		default: buf_pop = 1'b0;
		endcase
	end

	always @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg <= S_SYNC;
			boot_cnt_reg <= 8'h00;
			prog_cnt_reg <= 16'h0000;
			prog_data_reg <= 8'h00;
			read_reg <= 8'h00;
			portc0 <= `PORTC0_OFF;
			booted <= 1'b0;
			prog_addr <= {ADDR_W{1'b0}};
		end else begin
			case (state_reg)
			S_SYNC: begin
				if (buf_valid && buf_data == `SYNC_BYTE)
					state_reg <= S_BOOT;
			end
			S_BOOT: begin
				if (buf_pop) begin
					boot_mem[boot_cnt_reg] <= buf_data;
					boot_cnt_reg <= boot_cnt_reg + 8'h01;
					if (boot_cnt_reg == BOOT_LEN[7:0] - 8'h01) begin
						state_reg <= S_RUN;
						booted <= 1'b1;
						portc0 <= `PORTC0_ON;
						prog_addr <= {ADDR_W{1'b0}};
					end
				end
			end
			S_RUN: begin
				// host keeps one byte queued ahead while this one programs
				if (buf_valid) begin
					prog_data_reg <= buf_data;
					prog_cnt_reg <= PROG_CYCLES[15:0];
					state_reg <= S_PROG;
				end
			end
			S_PROG: begin
				if (prog_cnt_reg != 16'h0000) begin
					prog_cnt_reg <= prog_cnt_reg - 16'h0001;
				end else begin
					eprom[prog_addr] <= prog_data_reg;
					state_reg <= S_READ;
				end
			end
			S_READ: begin
				read_reg <= eprom[prog_addr];
				state_reg <= S_SEND;
			end
			S_SEND: begin
				if (!tx_busy_reg) begin
					// readback goes out; host verifies it against its copy
					prog_addr <= prog_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
					state_reg <= S_RUN;
				end
			end
			default: state_reg <= S_SYNC;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> verif/host_model.sv
/* host end of the serial link: sends and receives characters.
 * assumes the loader's bit time is BC core clock cycles. */
`timescale 1ns/1ps
`default_nettype none
module host_model #(parameter int BC = 16) (
	input wire logic clk,
	output logic rx_pin,
	input wire logic tx_pin
);
	// ----
	// line tasks
	// ----
	initial rx_pin = 1'b1;
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int k = 0; k < 10; k++) begin
			rx_pin <= f[k];
			repeat (BC) @(posedge clk);
		end
	endtask
	// sampling mid-bit tolerates a cycle of lag in spotting the start edge
	task automatic get(output logic [7:0] b, output bit ok, input int lim);
		b = 8'h00;
		ok = 1'b0;
		for (int n = 0; n < lim && tx_pin !== 1'b0; n++) @(posedge clk);
		if (tx_pin !== 1'b0) return;
		repeat (BC / 2) @(posedge clk);
		for (int k = 0; k < 8; k++) begin
			repeat (BC) @(posedge clk);
			b[k] = tx_pin;
		end
		repeat (BC) @(posedge clk);
		ok = (tx_pin === 1'b1);
	endtask
endmodule
`default_nettype wire

// >>> verif/loader_chk_chk.sv
/* pin-level assertions for the boot loader.
 * assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module loader_chk #(parameter ADDR_W = 13) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic rx_pin,
	input wire logic tx_pin,
	input wire logic portc0,
	input wire logic booted,
	input wire logic [ADDR_W-1:0] prog_addr
);
	// ----
	// checks
	// ----
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	AST_RST_VALUES: assert property (disable iff (1'b0)
		sys_rst |=> tx_pin && portc0 && !booted && prog_addr == '0) else $error("bad reset values");
	AST_BOOT_HOLD: assert property (booted |=> booted) else $error("boot flag dropped");
	AST_PORTC_LOW: assert property (booted |-> !portc0) else $error("port bit high after boot");
	AST_PORTC_HIGH: assert property (!booted |-> portc0) else $error("port bit low before boot");
	AST_ADDR_IDLE: assert property (!booted |-> prog_addr == '0) else $error("address moved early");
	AST_ADDR_STEP: assert property (!$past(sys_rst) && $changed(prog_addr) |->
		prog_addr == $past(prog_addr) + 1'b1) else $error("address step not one");
	AST_START_BIT: assert property ($fell(tx_pin) |-> !tx_pin[*8]) else $error("start bit too short");
	// the last boot byte is still echoed even though control passes at once
	AST_LAST_ECHO: assert property ($rose(booted) |-> ##[0:40] !tx_pin) else $error("last echo missing");
	cover property ($rose(booted));
	cover property ($changed(prog_addr));
	cover property (booted && $fell(rx_pin));
endmodule
bind serial_boot_eprom_loader loader_chk #(.ADDR_W(ADDR_W)) u_loader_chk (.core_clk(core_clk),
	.sys_rst(sys_rst), .rx_pin(rx_pin), .tx_pin(tx_pin), .portc0(portc0), .booted(booted),
	.prog_addr(prog_addr));
`default_nettype wire

// >>> verif/tb.sv
/* self-checking bench for the boot loader.
 * assumes the host model is the only driver of rx_pin. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ----
	// bench
	// ----
	localparam int BC = 16;
	typedef struct {logic [7:0] d; logic [7:0] e;} row_t;
	logic core_clk;
	logic sys_rst;
	wire rx_pin;
	wire tx_pin;
	wire portc0;
	wire booted;
	wire [12:0] prog_addr;
	int fails = 0;
	int total_checks = 0;
	int got;
	row_t rows [7] = '{'{8'h00, 8'h00}, '{8'ha5, 8'ha5}, '{8'h80, 8'h80}, '{8'hff, 8'hff},
		'{8'h01, 8'h01}, '{8'h5a, 8'h5a}, '{8'h7e, 8'h7e}};
	serial_boot_eprom_loader #(.BIT_CYCLES(BC), .BOOT_LEN(3), .PROG_CYCLES(20), .ADDR_W(13))
		u_serial_boot_eprom_loader (.core_clk(core_clk), .sys_rst(sys_rst), .rx_pin(rx_pin),
		.tx_pin(tx_pin), .portc0(portc0), .booted(booted), .prog_addr(prog_addr));
	host_model #(.BC(BC)) u_host_model (.clk(core_clk), .rx_pin(rx_pin), .tx_pin(tx_pin));
	task automatic check(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			fails++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// receiver runs beside the sender so replies overlap new characters
	task automatic xfer(input int lo, input int hi, input bit paced);
		logic [7:0] r;
		bit ok;
		got = 0;
		fork
			for (int i = lo; i < hi; i++) begin
				for (int w = 0; paced && got < i - lo - 1 && w < 4000; w++) @(posedge core_clk);
				if (paced && got < i - lo - 1) check(1'b0, "pacing wait ran out");
				u_host_model.send(rows[i].d);
			end
			for (int j = lo; j < hi; j++) begin
				u_host_model.get(r, ok, 60 * BC);
				check(ok && r === rows[j].e, "echo or readback wrong");
				got++;
			end
		join
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		logic [7:0] r;
		bit ok;
		sys_rst = 1'b1;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		u_host_model.send(8'h55);
		u_host_model.send(8'hff);
		u_host_model.get(r, ok, 30 * BC);
		check(!ok, "reply before boot code");
		$display("sync test done");
		xfer(0, 3, 1'b0);
		check(booted === 1'b1 && portc0 === 1'b0, "loaded code not started");
		$display("boot test done");
		xfer(3, 7, 1'b1);
		check(prog_addr === 13'h0004 && portc0 === 1'b0, "address after programming");
		$display("program test done");
		u_host_model.rx_pin <= 1'b0;
		repeat (10 * BC) @(posedge core_clk);
		u_host_model.rx_pin <= 1'b1;
		u_host_model.get(r, ok, 30 * BC);
		check(!ok && prog_addr === 13'h0004, "byte with low stop bit taken");
		$display("framing test done");
		sys_rst <= 1'b1;
		@(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		#1;
		check(!booted && portc0 && prog_addr === 13'h0000 && tx_pin === 1'b1, "reset values");
		$display("reset test done");
		wrap_up();
	end
endmodule
`default_nettype wire
